/* inc/pcie_cap_defs.svh */
// Offsets, field positions, reset values and timing counts of the PCIe capability block.
`default_nettype none
`ifndef PCIE_CAP_DEFS_SVH
`define PCIE_CAP_DEFS_SVH
`define CFG_OFS_DEV_CAP 8'h94
`define CFG_OFS_DEV_CTRL 8'h98
`define CFG_OFS_GEN_CTRL 8'hd4
`define CAP_ROLE_ERR_BIT 15
`define CAP_IND_LSB 12
`define CAP_L1_LSB 9
`define CAP_L0S_LSB 6
`define CAP_EXT_TAG_BIT 5
`define CAP_PHANTOM_LSB 3
`define CAP_PAYLOAD_LSB 0
`define CAP_PAYLOAD_CODE 3'h2
`define GEN_L1_LSB 13
`define GEN_L0S_LSB 16
`define LAT_RESET 3'h0
`define CTRL_RETRY_BIT 15
`define CTRL_MAX_READ_REQUEST_SIZE_LSB 12
`define CTRL_NS_BIT 11
`define CTRL_AUX_BIT 10
`define CTRL_RESET 16'h2800
`define MAX_READ_REQUEST_SIZE_MAX_CODE 3'h5
`define MAX_READ_REQUEST_SIZE_BASE_BYTES 13'h0080
`define CORE_CLK_NS 50
`define RETRY_TIMEOUT_NS 10000
`define RETRY_TIMEOUT_CYC ((`RETRY_TIMEOUT_NS) / (`CORE_CLK_NS))
`define RETRY_CNT_W 9
`endif
`default_nettype wire

/* inc/pcie_cap_pkg.sv */
// Types shared by the PCIe capability block.
`default_nettype none
package pcie_cap_pkg;
   typedef logic [2:0] lat_code_t;
   typedef logic [2:0] max_read_request_size_code_t;
   typedef logic [7:0] cfg_addr_t;
   typedef logic [31:0] cfg_word_t;
   typedef logic [12:0] fetch_bytes_t;
   typedef enum logic [0:0] {
      TMR_IDLE = 1'b0,
      TMR_WAIT = 1'b1
   } retry_state_t;
endpackage
`default_nettype wire

/* inc/bridge_side_if.sv */
// Signals between the capability core, the retry timer and the fetch sizer.
`default_nettype none
interface bridge_side_if;
   import pcie_cap_pkg::*;
   logic fwd_start;
   logic fwd_done;
   logic retry_busy;
   logic retry_expired;
   logic rd_req;
   max_read_request_size_code_t max_read_request_size_code;
   logic [7:0] cache_line;
   logic fetch_valid;
   fetch_bytes_t fetch_bytes;
   modport timer (input fwd_start, input fwd_done, output retry_busy, output retry_expired);
   modport sizer (input rd_req, input max_read_request_size_code, input cache_line,
                  output fetch_valid, output fetch_bytes);
   modport core (output fwd_start, output fwd_done, output rd_req, output max_read_request_size_code,
                 output cache_line, input retry_busy, input retry_expired,
                 input fetch_valid, input fetch_bytes);
endinterface
`default_nettype wire

/* hdl/cfg_retry_timer.sv */
// Timeout watch on one configuration transaction forwarded to the secondary side.
`include "pcie_cap_defs.svh"
`default_nettype none
module cfg_retry_timer (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   bridge_side_if.timer tif
);
   import pcie_cap_pkg::*;
   localparam logic [`RETRY_CNT_W-1:0] LAST = `RETRY_CNT_W'(`RETRY_TIMEOUT_CYC - 1);
   retry_state_t state_r;
   retry_state_t state_nxt;
   logic [`RETRY_CNT_W-1:0] cnt_r;
   logic expired_r;
   wire logic at_last = (cnt_r == LAST);
   wire logic fire = (state_r == TMR_WAIT) && !tif.fwd_done && at_last;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         TMR_IDLE: if (tif.fwd_start) state_nxt = TMR_WAIT;
         TMR_WAIT: if (tif.fwd_done || at_last) state_nxt = TMR_IDLE;
      endcase
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         state_r <= TMR_IDLE;
         cnt_r <= '0;
         expired_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= (state_r == TMR_WAIT) ? cnt_r + 1'b1 : '0;
         expired_r <= fire;
      end
   end
   assign tif.retry_busy = (state_r == TMR_WAIT);
   assign tif.retry_expired = expired_r;
   a_timer_expiry_ends: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      tif.retry_expired |-> !tif.retry_busy && $past(cnt_r) == LAST)
      else $error("retry timer expired at the wrong count");
endmodule // cfg_retry_timer
`default_nettype wire

/* hdl/read_fetch_sizer.sv */
// Fetch length of a read from the read request size and the cache line size.
`include "pcie_cap_defs.svh"
`default_nettype none
module read_fetch_sizer (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   bridge_side_if.sizer sif
);
   import pcie_cap_pkg::*;
   fetch_bytes_t bytes_r;
   logic valid_r;
   wire fetch_bytes_t max_read_request_size_bytes = fetch_bytes_t'(`MAX_READ_REQUEST_SIZE_BASE_BYTES << sif.max_read_request_size_code);
   wire fetch_bytes_t line_bytes = fetch_bytes_t'({sif.cache_line, 2'b00});
   wire logic use_line = (sif.cache_line != 8'h00) && (line_bytes < max_read_request_size_bytes);
   wire fetch_bytes_t size_nxt = use_line ? line_bytes : max_read_request_size_bytes;
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         bytes_r <= '0;
         valid_r <= 1'b0;
      end else begin
         valid_r <= sif.rd_req;
         if (sif.rd_req) bytes_r <= size_nxt;
      end
   end
   assign sif.fetch_valid = valid_r;
   assign sif.fetch_bytes = bytes_r;
   a_fetch_within_max_read_request_size: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      sif.rd_req |=> sif.fetch_valid && sif.fetch_bytes <= $past(max_read_request_size_bytes))
      else $error("fetch length exceeds read request size");
endmodule // read_fetch_sizer
`default_nettype wire

/* hdl/pcie_dev_cap_ctrl.sv */
// Device capabilities, device control and latency settings of the PCIe capability.
`include "pcie_cap_defs.svh"
`default_nettype none
module pcie_dev_cap_ctrl (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire pcie_cap_pkg::cfg_addr_t i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire pcie_cap_pkg::cfg_word_t i_cfg_wdata,
   output pcie_cap_pkg::cfg_word_t o_cfg_rdata,
   output logic o_cfg_ack,
   input wire pcie_cap_pkg::lat_code_t i_phy_l1_exit_lat,
   input wire pcie_cap_pkg::lat_code_t i_phy_l0s_exit_lat,
   input wire logic i_fwd_cfg_start,
   input wire logic i_fwd_cfg_done,
   output logic o_fwd_cfg_busy,
   output logic o_crs_cpl,
   input wire logic i_rd_req,
   input wire logic [7:0] i_cache_line_size,
   output logic o_fetch_valid,
   output pcie_cap_pkg::fetch_bytes_t o_fetch_bytes,
   input wire logic i_up_mem_valid,
   input wire logic i_up_mem_vc_nonzero,
   output logic o_no_snoop_valid,
   output logic o_tlp_no_snoop
);
   import pcie_cap_pkg::*;

   localparam logic [15:0] CTRL_RST = `CTRL_RESET;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   bridge_side_if bif ();

   logic retry_en_r;
   logic retry_en_nxt;
   max_read_request_size_code_t max_read_request_size_r;
   max_read_request_size_code_t max_read_request_size_nxt;
   logic ns_en_r;
   logic ns_en_nxt;
   logic aux_r;
   logic aux_nxt;
   lat_code_t l1_r;
   lat_code_t l1_nxt;
   lat_code_t l0s_r;
   lat_code_t l0s_nxt;
   cfg_word_t rdata_r;
   logic ack_r;
   logic crs_r;
   logic ns_valid_r;
   logic ns_flag_r;

   // Address decode on dword-aligned offsets.
   wire cfg_addr_t dw_addr = {i_cfg_addr[7:2], 2'b00};
   wire logic hit_cap = (dw_addr == `CFG_OFS_DEV_CAP);
   wire logic hit_ctrl = (dw_addr == `CFG_OFS_DEV_CTRL);
   wire logic hit_gen = (dw_addr == `CFG_OFS_GEN_CTRL);
   wire logic wr_ctrl = i_cfg_wr && hit_ctrl && i_cfg_be[1];
   wire logic wr_l1 = i_cfg_wr && hit_gen && i_cfg_be[1];
   wire logic wr_l0s = i_cfg_wr && hit_gen && i_cfg_be[2];

   // Write data fields.
   wire max_read_request_size_code_t max_read_request_size_wr = i_cfg_wdata[`CTRL_MAX_READ_REQUEST_SIZE_LSB +: 3];
   wire lat_code_t l1_wr = i_cfg_wdata[`GEN_L1_LSB +: 3];
   wire lat_code_t l0s_wr = i_cfg_wdata[`GEN_L0S_LSB +: 3];
   wire logic max_read_request_size_legal = (max_read_request_size_wr <= `MAX_READ_REQUEST_SIZE_MAX_CODE);

   wire lat_code_t l1_floor = (l1_wr < i_phy_l1_exit_lat) ? i_phy_l1_exit_lat : l1_wr;
   wire lat_code_t l0s_floor = (l0s_wr < i_phy_l0s_exit_lat) ? i_phy_l0s_exit_lat : l0s_wr;

   assign retry_en_nxt = wr_ctrl ? i_cfg_wdata[`CTRL_RETRY_BIT] : retry_en_r;
   assign max_read_request_size_nxt = (wr_ctrl && max_read_request_size_legal) ? max_read_request_size_wr : max_read_request_size_r;
   assign ns_en_nxt = wr_ctrl ? i_cfg_wdata[`CTRL_NS_BIT] : ns_en_r;
   assign aux_nxt = wr_ctrl ? i_cfg_wdata[`CTRL_AUX_BIT] : aux_r;
   assign l1_nxt = wr_l1 ? l1_floor : l1_r;
   assign l0s_nxt = wr_l0s ? l0s_floor : l0s_r;

   wire logic [15:0] ctrl_word = {retry_en_r, max_read_request_size_r, ns_en_r, aux_r, 10'h000};

   wire logic cap_role_err = 1'b1;
   wire logic [2:0] cap_ind = 3'h0;
   wire logic cap_etag = 1'b0;
   wire logic [1:0] cap_phantom = 2'h0;
   wire logic [2:0] cap_payload = `CAP_PAYLOAD_CODE;
   wire cfg_word_t cap_word = {16'h0000, cap_role_err, cap_ind, l1_r, l0s_r,
                               cap_etag, cap_phantom, cap_payload};
   wire cfg_word_t gen_word = {13'h0000, l0s_r, l1_r, 13'h0000};

   // Read mux; the status half of 98h and unmapped offsets read zero.
   wire cfg_word_t rdata_nxt = hit_cap ? cap_word :
                               hit_ctrl ? {16'h0000, ctrl_word} :
                               hit_gen ? gen_word : 32'h0000_0000;

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         retry_en_r <= CTRL_RST[`CTRL_RETRY_BIT];
         max_read_request_size_r <= CTRL_RST[`CTRL_MAX_READ_REQUEST_SIZE_LSB +: 3];
         ns_en_r <= CTRL_RST[`CTRL_NS_BIT];
         aux_r <= CTRL_RST[`CTRL_AUX_BIT];
      end else begin
         retry_en_r <= retry_en_nxt;
         max_read_request_size_r <= max_read_request_size_nxt;
         ns_en_r <= ns_en_nxt;
         aux_r <= aux_nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         l1_r <= `LAT_RESET;
         l0s_r <= `LAT_RESET;
      end else begin
         l1_r <= l1_nxt;
         l0s_r <= l0s_nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         rdata_r <= '0;
         ack_r <= 1'b0;
      end else begin
         ack_r <= i_cfg_rd || i_cfg_wr;
         if (i_cfg_rd) rdata_r <= rdata_nxt;
      end
   end

   // Forwarded configuration timeout and read sizing.
   assign bif.fwd_start = i_fwd_cfg_start;
   assign bif.fwd_done = i_fwd_cfg_done;
   assign bif.rd_req = i_rd_req;
   assign bif.max_read_request_size_code = max_read_request_size_r;
   assign bif.cache_line = i_cache_line_size;

   cfg_retry_timer u_retry_timer (
      .i_core_clk (i_core_clk),
      .i_nrst (i_nrst),
      .tif (bif.timer)
   );

   read_fetch_sizer u_fetch_sizer (
      .i_core_clk (i_core_clk),
      .i_nrst (i_nrst),
      .sif (bif.sizer)
   );

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         crs_r <= 1'b0;
      end else begin
         crs_r <= bif.retry_expired && retry_en_r;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         ns_valid_r <= 1'b0;
         ns_flag_r <= 1'b0;
      end else begin
         ns_valid_r <= i_up_mem_valid;
         if (i_up_mem_valid) ns_flag_r <= ns_en_r && i_up_mem_vc_nonzero;
      end
   end

   assign o_cfg_rdata = rdata_r;
   assign o_cfg_ack = ack_r;
   assign o_fwd_cfg_busy = bif.retry_busy;
   assign o_crs_cpl = crs_r;
   assign o_fetch_valid = bif.fetch_valid;
   assign o_fetch_bytes = bif.fetch_bytes;
   assign o_no_snoop_valid = ns_valid_r;
   assign o_tlp_no_snoop = ns_flag_r;

   a_cap_role_err: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_ack && o_cfg_rdata[`CAP_ROLE_ERR_BIT])
      else $error("role-based error bit not one");

   a_cap_ind_zero: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[`CAP_IND_LSB +: 3] == 3'h0)
      else $error("indicator or button bits not zero");

   a_cap_l1_mirror: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[`CAP_L1_LSB +: 3] == $past(l1_r))
      else $error("Setting_a field does not mirror setting");

   a_cap_l0s_mirror: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[`CAP_L0S_LSB +: 3] == $past(l0s_r))
      else $error("Setting_b field does not mirror setting");

   a_lat_reset_zero: assert property (
      !$past(i_nrst) |-> l1_r == `LAT_RESET && l0s_r == `LAT_RESET)
      else $error("latency fields not zero after reset");

   a_l1_floor_kept: assert property (
      wr_l1 |=> l1_r >= $past(i_phy_l1_exit_lat) && l1_r >= $past(l1_wr))
      else $error("Setting_a written below PHY exit latency");

   a_l0s_floor_kept: assert property (
      wr_l0s |=> l0s_r >= $past(i_phy_l0s_exit_lat) && l0s_r >= $past(l0s_wr))
      else $error("Setting_b written below PHY exit latency");

   a_cap_etag_zero: assert property (
      i_cfg_rd && hit_cap |=> !o_cfg_rdata[`CAP_EXT_TAG_BIT])
      else $error("extended tag bit not zero");

   a_cap_phantom_zero: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[`CAP_PHANTOM_LSB +: 2] == 2'h0)
      else $error("phantom function bits not zero");

   a_cap_payload_code: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[`CAP_PAYLOAD_LSB +: 3] == `CAP_PAYLOAD_CODE)
      else $error("max payload supported code wrong");

   a_retry_cpl_sent: assert property (
      bif.retry_expired && retry_en_r |=> o_crs_cpl ##1 !o_crs_cpl)
      else $error("retry completion missing after timeout");

   a_retry_cpl_off: assert property (
      !retry_en_r |=> !o_crs_cpl)
      else $error("retry completion while retry disabled");

   a_max_read_request_size_write_legal: assert property (
      wr_ctrl && max_read_request_size_legal |=> max_read_request_size_r == $past(max_read_request_size_wr))
      else $error("read request size not taken");

   a_max_read_request_size_reserved_kept: assert property (
      wr_ctrl && !max_read_request_size_legal |=> $stable(max_read_request_size_r))
      else $error("reserved read request size code stored");

   a_no_snoop_copy: assert property (
      i_up_mem_valid |=> o_no_snoop_valid
         && o_tlp_no_snoop == $past(ns_en_r && i_up_mem_vc_nonzero))
      else $error("no snoop flag not copied");

   a_aux_stored: assert property (
      wr_ctrl |=> aux_r == $past(i_cfg_wdata[`CTRL_AUX_BIT]))
      else $error("aux power enable not stored");

   a_ctrl_reset_val: assert property (
      !$past(i_nrst) |-> ctrl_word == CTRL_RST)
      else $error("device control word reset value wrong");

   a_ro_write_ignored: assert property (
      i_cfg_wr && hit_cap |=> $stable(ctrl_word) && $stable(l1_r) && $stable(l0s_r))
      else $error("write to capability word changed state");

   a_cfg_ack_pulse: assert property (
      i_cfg_rd || i_cfg_wr |=> o_cfg_ack)
      else $error("configuration access not acknowledged");

   a_cfg_ack_idle: assert property (
      !(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack)
      else $error("acknowledge without an access");

   a_ctrl_read_word: assert property (
      i_cfg_rd && hit_ctrl |=> o_cfg_rdata == {16'h0000, $past(ctrl_word)})
      else $error("control word read back wrong");

   a_ctrl_lane_gate: assert property (
      i_cfg_wr && hit_ctrl && !i_cfg_be[1] |=> $stable(ctrl_word))
      else $error("control word changed without its byte enable");

   a_rdata_holds: assert property (
      !i_cfg_rd |=> $stable(o_cfg_rdata))
      else $error("read data changed without a read");

   a_gen_read_word: assert property (
      i_cfg_rd && hit_gen |=> o_cfg_rdata[`GEN_L1_LSB +: 3] == $past(l1_r)
         && o_cfg_rdata[`GEN_L0S_LSB +: 3] == $past(l0s_r))
      else $error("latency settings read back wrong");

   a_gen_spare_zero: assert property (
      i_cfg_rd && hit_gen |=> o_cfg_rdata[31:19] == 13'h0000
         && o_cfg_rdata[12:0] == 13'h0000)
      else $error("unimplemented general control bits not zero");

   a_cap_upper_zero: assert property (
      i_cfg_rd && hit_cap |=> o_cfg_rdata[31:16] == 16'h0000)
      else $error("upper capability bits not zero");

   a_unmapped_zero: assert property (
      i_cfg_rd && !hit_cap && !hit_ctrl && !hit_gen |=> o_cfg_rdata == 32'h0000_0000)
      else $error("unmapped offset did not read zero");

   a_retry_en_write: assert property (
      wr_ctrl |=> retry_en_r == $past(i_cfg_wdata[`CTRL_RETRY_BIT]))
      else $error("retry enable not stored");

   a_ns_en_write: assert property (
      wr_ctrl |=> ns_en_r == $past(i_cfg_wdata[`CTRL_NS_BIT]))
      else $error("no snoop enable not stored");

   a_max_read_request_size_code_legal: assert property (
      max_read_request_size_r <= `MAX_READ_REQUEST_SIZE_MAX_CODE)
      else $error("reserved read request size code held");

   a_l1_hold_idle: assert property (
      !wr_l1 |=> $stable(l1_r))
      else $error("Setting_a changed without a write");

   a_l0s_hold_idle: assert property (
      !wr_l0s |=> $stable(l0s_r))
      else $error("Setting_b changed without a write");

   a_ns_vc0_clear: assert property (
      i_up_mem_valid && !i_up_mem_vc_nonzero |=> !o_tlp_no_snoop)
      else $error("no snoop set on a VC0 transaction");

   a_ns_flag_holds: assert property (
      !i_up_mem_valid |=> $stable(o_tlp_no_snoop))
      else $error("no snoop flag changed without a transaction");

   a_busy_after_start: assert property (
      i_fwd_cfg_start && !o_fwd_cfg_busy |=> o_fwd_cfg_busy)
      else $error("forwarded transaction not watched");

   a_done_ends_wait: assert property (
      o_fwd_cfg_busy && i_fwd_cfg_done |=> !o_fwd_cfg_busy ##1 !o_crs_cpl)
      else $error("completed transaction still timed out");

   a_retry_cpl_cause: assert property (
      o_crs_cpl |-> $past(bif.retry_expired) && $past(retry_en_r))
      else $error("retry completion without an enabled timeout");

   a_retry_cpl_single: assert property (
      o_crs_cpl |=> !o_crs_cpl)
      else $error("retry completion longer than one cycle");

   a_fetch_bytes_hold: assert property (
      !i_rd_req |=> $stable(o_fetch_bytes))
      else $error("fetch length changed without a request");

endmodule // pcie_dev_cap_ctrl
`default_nettype wire

/* dv/cfg_host_model.sv */
// Host model that issues configuration reads and writes to the block.
`default_nettype none
module cfg_host_model (
   input wire logic i_core_clk,
   input wire pcie_cap_pkg::cfg_word_t i_cfg_rdata,
   input wire logic i_cfg_ack,
   output logic o_cfg_wr,
   output logic o_cfg_rd,
   output pcie_cap_pkg::cfg_addr_t o_cfg_addr,
   output logic [3:0] o_cfg_be,
   output pcie_cap_pkg::cfg_word_t o_cfg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import pcie_cap_pkg::*;

   initial begin
      o_cfg_wr = 1'b0;
      o_cfg_rd = 1'b0;
      o_cfg_addr = 8'h00;
      o_cfg_be = 4'h0;
      o_cfg_wdata = 32'h0;
   end

   // One strobe cycle, then a bounded wait for the acknowledge.
   task automatic xfer(input logic w, input cfg_addr_t a, input logic [3:0] b,
                       input cfg_word_t d, output cfg_word_t q);
      int n;
      n = 0;
      @(posedge i_core_clk);
      #1;
      o_cfg_wr = w;
      o_cfg_rd = ~w;
      o_cfg_addr = a;
      o_cfg_be = b;
      o_cfg_wdata = d;
      @(posedge i_core_clk);
      #1;
      o_cfg_wr = 1'b0;
      o_cfg_rd = 1'b0;
      o_cfg_addr = ~a;
      o_cfg_be = ~b;
      o_cfg_wdata = ~d;
      while (i_cfg_ack !== 1'b1 && n < 4) begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      q = (i_cfg_ack === 1'b1) ? i_cfg_rdata : 'x;
   endtask
endmodule // cfg_host_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the device capability and control block.
`include "pcie_cap_defs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pcie_cap_pkg::*;
   localparam cfg_addr_t cap_a = `CFG_OFS_DEV_CAP;
   localparam cfg_addr_t ctl_a = `CFG_OFS_DEV_CTRL;
   localparam cfg_addr_t gen_a = `CFG_OFS_GEN_CTRL;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cfg_wr, cfg_rd, ack, busy, crs, fv, nsv, nsf;
   logic start = 1'b0, done = 1'b0, rd_req = 1'b0, mem_v = 1'b0, vc = 1'b0;
   logic [3:0] be;
   logic [7:0] cls = 8'h00;
   cfg_addr_t addr;
   cfg_word_t wdata, rdata, q;
   lat_code_t l1f = 3'h0, l0f = 3'h0;
   fetch_bytes_t fb;
   int err_total = 0, total_checks = 0;

   always #25 clk = ~clk;

   pcie_dev_cap_ctrl dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_cfg_wr(cfg_wr),
      .i_cfg_rd(cfg_rd), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
      .o_cfg_rdata(rdata), .o_cfg_ack(ack), .i_phy_l1_exit_lat(l1f),
      .i_phy_l0s_exit_lat(l0f), .i_fwd_cfg_start(start), .i_fwd_cfg_done(done),
      .o_fwd_cfg_busy(busy), .o_crs_cpl(crs), .i_rd_req(rd_req),
      .i_cache_line_size(cls), .o_fetch_valid(fv), .o_fetch_bytes(fb),
      .i_up_mem_valid(mem_v), .i_up_mem_vc_nonzero(vc), .o_no_snoop_valid(nsv),
      .o_tlp_no_snoop(nsf));

   cfg_host_model host_u (.i_core_clk(clk), .i_cfg_rdata(rdata), .i_cfg_ack(ack),
      .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd), .o_cfg_addr(addr), .o_cfg_be(be),
      .o_cfg_wdata(wdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input cfg_addr_t a, input logic [3:0] b, input cfg_word_t d);
      host_u.xfer(1'b1, a, b, d, q);
      chk({31'h0, q !== 'x}, 32'h1, "write ack");
   endtask

   task automatic rd_chk(input cfg_addr_t a, input cfg_word_t e, input string what);
      host_u.xfer(1'b0, a, 4'h0, 32'h0, q);
      chk(q, e, what);
   endtask

   task automatic t_reset();
      chk({ack, busy, crs, fv, nsv}, 32'h0, "idle outputs");
      rd_chk(cap_a, 32'h0000_8002, "caps");
      rd_chk(ctl_a, 32'h0000_2800, "ctrl");
      rd_chk(gen_a, 32'h0, "gen");
      rd_chk(8'h9c, 32'h0, "unmapped");
   endtask

   task automatic t_lat();
      wr(gen_a, 4'hf, 32'hffff_ffff);
      rd_chk(gen_a, 32'h0007_e000, "gen all");
      rd_chk(cap_a, 32'h0000_8fc2, "caps max");
      l1f = 3'h2;
      l0f = 3'h3;
      wr(gen_a, 4'h6, 32'h0005_2000);
      rd_chk(cap_a, 32'h0000_8542, "l1 floor");
      wr(gen_a, 4'h4, 32'h0);
      rd_chk(gen_a, 32'h0003_4000, "l0s floor");
      wr(cap_a, 4'hf, 32'hffff_ffff);
      rd_chk(cap_a, 32'h0000_84c2, "caps ro");
   endtask

   task automatic t_ctrl();
      wr(ctl_a, 4'hd, 32'h0);
      rd_chk(ctl_a, 32'h0000_2800, "lane gate");
      wr(ctl_a, 4'hf, 32'hffff_ffff);
      rd_chk(ctl_a, 32'h0000_ac00, "ctrl all");
      wr(ctl_a, 4'h2, 32'h0000_6000);
      rd_chk(ctl_a, 32'h0000_2000, "max_read_request_size rsvd");
   endtask

   task automatic fetch(input logic [7:0] c, input fetch_bytes_t e);
      @(posedge clk);
      #1;
      cls = c;
      rd_req = 1'b1;
      @(posedge clk);
      #1;
      rd_req = 1'b0;
      chk({fv, fb}, {1'b1, e}, "fetch");
   endtask

   task automatic t_max_read_request_size();
      fetch_bytes_t e;
      for (int c = 0; c < 6; c++) begin
         e = fetch_bytes_t'(13'h0080 << c);
         wr(ctl_a, 4'h2, {16'h0, 1'b0, c[2:0], 12'h0});
         rd_chk(ctl_a, {16'h0, 1'b0, c[2:0], 12'h0}, "max_read_request_size");
         fetch(8'h00, e);
         fetch(8'h40, (e > 13'h0100) ? 13'h0100 : e);
      end
   endtask

   task automatic ns(input logic v, input logic e);
      @(posedge clk);
      #1;
      mem_v = 1'b1;
      vc = v;
      @(posedge clk);
      #1;
      mem_v = 1'b0;
      vc = ~v;
      chk({nsv, nsf}, {1'b1, e}, "no snoop");
   endtask

   task automatic t_ns();
      wr(ctl_a, 4'h2, 32'h0000_0c00);
      ns(1'b1, 1'b1);
      ns(1'b0, 1'b0);
      wr(ctl_a, 4'h2, 32'h0000_0400);
      ns(1'b1, 1'b0);
   endtask

   task automatic retry(input int done_at, input int exp_at);
      int seen;
      seen = 0;
      @(posedge clk);
      #1;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      chk(busy, 32'h1, "busy");
      for (int k = 1; k < 206; k++) begin
         done = (k == done_at);
         if (crs === 1'b1) begin
            seen = k;
         end
         @(posedge clk);
         #1;
      end
      done = 1'b0;
      chk(seen, exp_at, "retry");
      chk(busy, 32'h0, "idle");
   endtask

   task automatic t_retry();
      wr(ctl_a, 4'h2, 32'h0);
      retry(0, 0);
      wr(ctl_a, 4'h2, 32'h0000_8000);
      retry(0, `RETRY_TIMEOUT_CYC + 2);
      retry(50, 0);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_lat();
      t_ctrl();
      t_max_read_request_size();
      t_ns();
      t_retry();
      test_done();
   end

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
